// [core/asr_pkg.sv]
// Shared constants of the converter configuration register slice.
// Assumes byte-wide registers behind a 4-wire serial port, 15-bit addresses.

package asr_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int POS_W  = 24;
    localparam int DLY_W  = 4;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [14:0] OFS_CONFIG      = 15'h000;
    localparam logic [14:0] OFS_FAMILY_LO   = 15'h004;
    localparam logic [14:0] OFS_FAMILY_HI   = 15'h005;
    localparam logic [14:0] OFS_VERSION     = 15'h006;
    localparam logic [14:0] OFS_MAKER_LO    = 15'h00c;
    localparam logic [14:0] OFS_MAKER_HI    = 15'h00d;
    localparam logic [14:0] OFS_USER_CFG    = 15'h010;
    localparam logic [14:0] OFS_CLK_A       = 15'h029;
    localparam logic [14:0] OFS_CLK_B       = 15'h02a;
    localparam logic [14:0] OFS_POS_0       = 15'h02c;
    localparam logic [14:0] OFS_POS_1       = 15'h02d;
    localparam logic [14:0] OFS_POS_2       = 15'h02e;
    localparam logic [14:0] OFS_FS_A_LO     = 15'h030;
    localparam logic [14:0] OFS_FS_A_HI     = 15'h031;
    localparam logic [14:0] OFS_FS_B_LO     = 15'h032;
    localparam logic [14:0] OFS_FS_B_HI     = 15'h033;
    localparam logic [14:0] OFS_BYPASS      = 15'h038;
    localparam logic [14:0] OFS_SYNC_CTRL   = 15'h03b;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_ADDR_DIR   = 5;
    localparam int BIT_SDO_ACTIVE = 4;
    localparam int BIT_ADDR_HOLD  = 0;
    localparam int BIT_PROC_EN    = 6;
    localparam int BIT_RECV_EN    = 5;
    localparam int BIT_ZOOM       = 4;
    localparam int DLY_LSB        = 0;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic        RST_ADDR_DIR  = 1'b1;
    localparam logic        RST_ADDR_HOLD = 1'b0;
    localparam logic [7:0]  RST_CLK_A     = 8'h00;
    localparam logic [7:0]  RST_CLK_B     = 8'h20;
    localparam logic [15:0] RST_FS        = 16'ha000;
    localparam logic [7:0]  RST_BYPASS    = 8'h00;
    localparam logic [7:0]  RST_SYNC_CTRL = 8'h00;
    localparam logic [3:0]  DLY_AUTO      = 4'h0;

    // ------------------------------------------------------------------
    // Frame timing, in serial clock bits
    // ------------------------------------------------------------------
    localparam logic [3:0]  HDR_LAST      = 4'hf;
    localparam logic [2:0]  BYTE_LAST     = 3'h7;

endpackage

// [core/asr_spi_port.sv]
// Serial port front end: pin synchronisers, header and byte framing.
// Assumes the serial clock runs at most one eighth of mclk.
`timescale 1ns/100ps
`default_nettype none

module asr_spi_port
    import asr_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire logic                 spi_sclk,
    input  wire logic                 spi_cs_n,
    input  wire logic                 spi_sdi,
    output logic                      spi_sdo,
    output logic                      spi_sdo_oe,
    input  wire logic [7:0]           rd_byte,
    output logic                      hdr_stb,
    output logic                      hdr_rnw,
    output logic [asr_pkg::ADDR_W-1:0] hdr_addr,
    output logic                      byte_stb,
    output logic [7:0]                byte_data
);
    import asr_pkg::*;

    typedef struct packed {
        logic [2:0]  sclk_s;
        logic [1:0]  csn_s;
        logic [1:0]  sdi_s;
        logic [15:0] shin;
        logic [3:0]  cnt;
        logic        data_ph;
        logic        rnw;
        logic [14:0] addr;
        logic [7:0]  shout;
        logic        hdr_p;
        logic        byte_p;
        logic [7:0]  wbyte;
    } asr_spi_st_t;

    asr_spi_st_t q;
    asr_spi_st_t d;
    logic        sel;
    logic        rise;
    logic        fall;
    logic [15:0] shin_n;

    // ------------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------------
    // Edges seen on second and third stages only; first stage is private
    assign sel    = ~q.csn_s[1];
    assign rise   = q.sclk_s[1] & ~q.sclk_s[2];
    assign fall   = ~q.sclk_s[1] & q.sclk_s[2];
    assign shin_n = {q.shin[14:0], q.sdi_s[1]};

    always_comb begin
        d        = q;
        d.hdr_p  = 1'b0;
        d.byte_p = 1'b0;
        d.sclk_s = {q.sclk_s[1:0], spi_sclk};
        d.csn_s  = {q.csn_s[0], spi_cs_n};
        d.sdi_s  = {q.sdi_s[0], spi_sdi};
        if (!sel) begin
            d.cnt     = 4'h0;
            d.data_ph = 1'b0;
        end else if (rise) begin
            d.shin = shin_n;
            if (!q.data_ph) begin
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == HDR_LAST) begin
                    d.data_ph = 1'b1;
                    d.cnt     = 4'h0;
                    d.hdr_p   = 1'b1;
                    d.rnw     = shin_n[15];
                    d.addr    = shin_n[14:0];
                end
            end else begin
                d.cnt = {1'b0, q.cnt[2:0] + 3'h1};
                if (q.cnt[2:0] == BYTE_LAST) begin
                    d.byte_p = 1'b1;
                    d.wbyte  = shin_n[7:0];
                end
            end
        end else if (fall && q.data_ph) begin
            // Load on the first fall of each byte, address already moved
            if (q.cnt[2:0] == 3'h0) begin
                d.shout = rd_byte;
            end else begin
                d.shout = {q.shout[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q       <= '0;
            q.csn_s <= 2'b11;
        end else if (ce) begin
            q <= d;
        end
    end

    // Drive only in the data phase of a read, so writes never collide
    assign spi_sdo    = q.shout[7];
    assign spi_sdo_oe = sel & q.data_ph & q.rnw;
    assign hdr_stb    = q.hdr_p;
    assign hdr_rnw    = q.rnw;
    assign hdr_addr   = q.addr;
    assign byte_stb   = q.byte_p;
    assign byte_data  = q.wbyte;

endmodule

`default_nettype wire

// [core/asr_regs.sv]
// Identity, serial-port and sync-clock control register slice.
// Assumes the analog side supplies a quasi-static edge phase word.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// RL1 - Chip identity reads a fixed 16-bit code over two bytes; writes ignored.
// RL2 - Silicon version byte reads a fixed constant on every read.
// RL3 - Maker identity reads a fixed 16-bit code from 0x00c over two bytes.
// RL4 - Hold clear: streaming address moves as the direction bit says.
// RL5 - Hold set: streaming address stays fixed for every byte.
// RL6 - Direction 0 decrements, 1 increments; resets to 1.
// RL7 - Sync events are processed only while processor enable is set.
// RL8 - Host enables the receiver no later than the processor enable.
// RL9 - Receiver enable powers the sync input receiver; off while clear.
// RL10 - Magnify bit changes resolution of the reported edge position.
// RL11 - Delay select picks the capture tap; zero means automatic calibration.
// RL12 - Host picks the delay value from the edge position readback.
// RL13 - Edge position is a 24-bit read-only status vs sample clock.
// RL14 - Reserved bits and unmapped addresses read zero; writes do nothing. OFS_CLK_A bit 7 is stored and reads back as written.
module asr_regs
    import asr_pkg::*;
#(
    // Arbitrary identity values, not those of any real part
    parameter logic [15:0] CHIP_IDENTITY_CODE = 16'h00a5,
    parameter logic [7:0]  SILICON_VERSION    = 8'h03,
    parameter logic [15:0] MAKER_IDENTITY     = 16'h1234
)
(
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire logic                   spi_sclk,
    input  wire logic                   spi_cs_n,
    input  wire logic                   spi_sdi,
    output logic                        spi_sdo,
    output logic                        spi_sdo_oe,
    input  wire logic                   sysref_pin,
    input  wire logic [asr_pkg::POS_W-1:0] edge_phase,
    output logic                        sysref_receiver_enable,
    output logic                        sysref_processor_enable,
    output logic                        sysref_position_magnify,
    output logic [asr_pkg::DLY_W-1:0]   sysref_delay_select,
    output logic                        sysref_auto_cal,
    output logic                        sysref_event,
    output logic [7:0]                  sync_clock_control_b,
    output logic [15:0]                 input_a_full_scale,
    output logic [15:0]                 input_b_full_scale,
    output logic [7:0]                  reference_bypass,
    output logic [7:0]                  timestamp_input_control
);
    import asr_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              dir;
        logic              hold;
        logic [7:0]        clk_a;
        logic [7:0]        clk_b;
        logic [15:0]       fs_a;
        logic [15:0]       fs_b;
        logic [7:0]        bypass;
        logic [7:0]        sync_ctrl;
        logic [14:0]       addr;
        logic [1:0]        sref_s;
        logic              sref_prev;
        logic [POS_W-1:0]  ph_s1;
        logic [POS_W-1:0]  ph_s2;
        logic [POS_W-1:0]  pos;
        logic              evt;
    } asr_reg_st_t;

    localparam asr_reg_st_t RST_STATE = '{
        dir:       RST_ADDR_DIR,
        hold:      RST_ADDR_HOLD,
        clk_a:     RST_CLK_A,
        clk_b:     RST_CLK_B,
        fs_a:      RST_FS,
        fs_b:      RST_FS,
        bypass:    RST_BYPASS,
        sync_ctrl: RST_SYNC_CTRL,
        default:   '0
    };

    asr_reg_st_t      q;
    asr_reg_st_t      d;
    logic [7:0]       rd_byte;
    logic             hdr_stb;
    logic             hdr_rnw;
    logic [14:0]      hdr_addr;
    logic             byte_stb;
    logic [7:0]       byte_data;
    logic             rnw_q;
    logic             recv_on;
    logic             proc_on;
    logic             sref_rise;
    logic [POS_W-1:0] pos_view;

    // ------------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------------
    asr_spi_port u_port (
        .mclk       (mclk),
        .rst        (rst),
        .ce         (ce),
        .spi_sclk   (spi_sclk),
        .spi_cs_n   (spi_cs_n),
        .spi_sdi    (spi_sdi),
        .spi_sdo    (spi_sdo),
        .spi_sdo_oe (spi_sdo_oe),
        .rd_byte    (rd_byte),
        .hdr_stb    (hdr_stb),
        .hdr_rnw    (hdr_rnw),
        .hdr_addr   (hdr_addr),
        .byte_stb   (byte_stb),
        .byte_data  (byte_data)
    );

    // Port holds the frame direction for the whole frame
    assign rnw_q = hdr_rnw;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Read mux on the current streaming address
    always_comb begin
        rd_byte = 8'h00;
        case (q.addr)
            OFS_CONFIG: begin
                rd_byte[BIT_ADDR_DIR]   = q.dir;
                rd_byte[BIT_SDO_ACTIVE] = 1'b1;
            end
            // RL1 fixed chip code
            OFS_FAMILY_LO:  rd_byte = CHIP_IDENTITY_CODE[7:0];
            OFS_FAMILY_HI:  rd_byte = CHIP_IDENTITY_CODE[15:8];
            // RL2 fixed version byte
            OFS_VERSION:    rd_byte = SILICON_VERSION;
            // RL3 fixed maker code
            OFS_MAKER_LO:   rd_byte = MAKER_IDENTITY[7:0];
            OFS_MAKER_HI:   rd_byte = MAKER_IDENTITY[15:8];
            OFS_USER_CFG:   rd_byte[BIT_ADDR_HOLD] = q.hold;
            OFS_CLK_A:      rd_byte = q.clk_a;
            OFS_CLK_B:      rd_byte = q.clk_b;
            // RL13 position status bytes
            OFS_POS_0:      rd_byte = q.pos[7:0];
            OFS_POS_1:      rd_byte = q.pos[15:8];
            OFS_POS_2:      rd_byte = q.pos[23:16];
            OFS_FS_A_LO:    rd_byte = q.fs_a[7:0];
            OFS_FS_A_HI:    rd_byte = q.fs_a[15:8];
            OFS_FS_B_LO:    rd_byte = q.fs_b[7:0];
            OFS_FS_B_HI:    rd_byte = q.fs_b[15:8];
            OFS_BYPASS:     rd_byte = q.bypass;
            OFS_SYNC_CTRL:  rd_byte = q.sync_ctrl;
            // RL14 unmapped reads zero
            default:        rd_byte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Sync edge position
    // ------------------------------------------------------------------
    // RL10 magnify selects resolution
    // Unmagnified view merges bit pairs, halving resolution
    for (genvar i = 0; i < POS_W; i++) begin : g_pos
        assign pos_view[i] = q.clk_a[BIT_ZOOM] ? q.ph_s2[i]
                           : (q.ph_s2[2*(i/2)] | q.ph_s2[2*(i/2)+1]);
    end

    // RL9 receiver gates the pin
    assign recv_on   = q.clk_a[BIT_RECV_EN];
    assign proc_on   = q.clk_a[BIT_PROC_EN];
    assign sref_rise = recv_on & q.sref_s[1] & ~q.sref_prev;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d           = q;
        d.sref_s    = {q.sref_s[0], sysref_pin};
        d.sref_prev = q.sref_s[1];
        d.ph_s1     = edge_phase;
        d.ph_s2     = q.ph_s1;
        // RL7 events only while processing
        d.evt       = sref_rise & proc_on;
        // RL13 capture edge position
        if (sref_rise & proc_on) begin
            d.pos = pos_view;
        end
        // Header loads the start address of the stream
        if (hdr_stb) begin
            d.addr = hdr_addr;
        end
        // Writes only in write frames; RL14 unmapped writes dropped
        if (byte_stb && !rnw_q) begin
            case (q.addr)
                OFS_CONFIG:    d.dir = byte_data[BIT_ADDR_DIR];
                OFS_USER_CFG:  d.hold = byte_data[BIT_ADDR_HOLD];
                OFS_CLK_A:     d.clk_a = byte_data;
                OFS_CLK_B:     d.clk_b = byte_data;
                OFS_FS_A_LO:   d.fs_a[7:0] = byte_data;
                OFS_FS_A_HI:   d.fs_a[15:8] = byte_data;
                OFS_FS_B_LO:   d.fs_b[7:0] = byte_data;
                OFS_FS_B_HI:   d.fs_b[15:8] = byte_data;
                OFS_BYPASS:    d.bypass = byte_data;
                OFS_SYNC_CTRL: d.sync_ctrl = byte_data;
                default:       d.addr = d.addr;
            endcase
        end
        // Advance uses the hold and direction seen before this byte
        if (byte_stb) begin
            // RL5 hold keeps address
            if (q.hold) begin
                d.addr = q.addr;
            // RL4 RL6 step by direction
            end else if (q.dir) begin
                d.addr = q.addr + 15'h1;
            end else begin
                d.addr = q.addr - 15'h1;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= RST_STATE;
        end else if (ce) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign sysref_receiver_enable  = recv_on;
    assign sysref_processor_enable = proc_on;
    assign sysref_position_magnify = q.clk_a[BIT_ZOOM];
    assign sysref_delay_select     = q.clk_a[DLY_LSB +: DLY_W];
    // RL11 zero selects auto calibration
    assign sysref_auto_cal         = (q.clk_a[DLY_LSB +: DLY_W] == DLY_AUTO);
    assign sysref_event            = q.evt;
    assign sync_clock_control_b    = q.clk_b;
    assign input_a_full_scale      = q.fs_a;
    assign input_b_full_scale      = q.fs_b;
    assign reference_bypass        = q.bypass;
    assign timestamp_input_control = q.sync_ctrl;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence seq_byte_held;
        byte_stb && ce && q.hold;
    endsequence

    sequence seq_byte_up;
        byte_stb && ce && !q.hold && q.dir;
    endsequence

    sequence seq_byte_down;
        byte_stb && ce && !q.hold && !q.dir;
    endsequence

    AST_FAMILY_CODE: assert property ( // RL1
        (q.addr == OFS_FAMILY_LO) |-> rd_byte == CHIP_IDENTITY_CODE[7:0])
        else $error("chip identity low byte wrong");

    AST_VERSION: assert property ( // RL2
        (q.addr == OFS_VERSION) |-> rd_byte == SILICON_VERSION)
        else $error("silicon version byte wrong");

    AST_MAKER: assert property ( // RL3
        (q.addr == OFS_MAKER_HI) |-> rd_byte == MAKER_IDENTITY[15:8])
        else $error("maker identity high byte wrong");

    AST_STEP_UP: assert property ( // RL4
        seq_byte_up |=> q.addr == $past(q.addr) + 15'h1)
        else $error("ascending stream did not increment");

    AST_HOLD: assert property ( // RL5
        seq_byte_held ##1 !hdr_stb |-> q.addr == $past(q.addr))
        else $error("held address moved");

    AST_STEP_DOWN: assert property ( // RL6
        seq_byte_down |=> q.addr == $past(q.addr) - 15'h1)
        else $error("descending stream did not decrement");

    AST_PROC_GATE: assert property ( // RL7
        sysref_event |-> $past(proc_on) && $past(sref_rise))
        else $error("event without processor enable");

    AST_RECV_GATE: assert property ( // RL9
        !recv_on && ce |=> !sysref_event)
        else $error("event while receiver disabled");

    AST_AUTO_CAL: assert property ( // RL11
        sysref_auto_cal |-> sysref_delay_select == DLY_AUTO)
        else $error("auto calibration with nonzero tap");

    AST_RESERVED: assert property ( // RL14
        (q.addr == OFS_POS_2 + 15'h1) |-> rd_byte == 8'h00)
        else $error("reserved address read nonzero");

endmodule

`default_nettype wire

// [tb/asr_host_model.sv]
// Host serial controller model for the four-wire configuration port.
// Assumes the port samples on sclk rise and the design drives sdo after falls.
`timescale 1ns/100ps
`default_nettype none

module asr_host_model (
    input  wire logic       mclk,
    input  wire logic       sdo,
    output logic            sclk,
    output logic            cs_n,
    output logic            sdi,
    output logic            rd_stb,
    output logic [7:0]      rd_byte
);
    // Half serial period; above the four mclk floor of the port
    localparam int HALF = 5;

    initial begin
        sclk    = 1'b0;
        cs_n    = 1'b1;
        sdi     = 1'b0;
        rd_stb  = 1'b0;
        rd_byte = 8'h00;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // ------------------------------------------------------------------
    // One frame: R/W bit, 15 address bits, then n bytes, first byte on top
    // ------------------------------------------------------------------
    task automatic xfer(input logic rnw, input logic [14:0] adr,
                        input int n, input logic [63:0] wd);
        logic [15:0] hdr;
        logic [7:0]  sh;
        hdr = {rnw, adr};
        sh  = 8'h00;
        @(posedge mclk);
        cs_n <= 1'b0;
        for (int i = 0; i < 16 + 8 * n; i++) begin
            sclk <= 1'b0;
            sdi  <= (i < 16) ? hdr[15 - i] : wd[8 * n - 1 - (i - 16)];
            tick(HALF);
            // Sampled at the rise, well after the design moved sdo
            sclk <= 1'b1;
            sh = {sh[6:0], sdo};
            if (rnw && i >= 16 && (i - 15) % 8 == 0) begin
                rd_byte <= sh;
                rd_stb  <= 1'b1;
            end
            tick(1);
            rd_stb <= 1'b0;
            tick(HALF - 1);
        end
        sclk <= 1'b0;
        tick(HALF);
        // Released data line does not keep its last level
        cs_n <= 1'b1;
        sdi  <= ~sdi;
        tick(6);
    endtask
endmodule
`default_nettype wire

// [tb/test_adc_id_and_sysref_cfg_regs.sv]
// Self-checking bench of the identity and sync clock register slice.
// Assumes asr_regs with its serial port, driven through the host model.
`timescale 1ns/100ps
`default_nettype none

module test_adc_id_and_sysref_cfg_regs;
    import asr_pkg::*;
    // Identity values are arbitrary, chosen for this bench only
    localparam logic [15:0] CID = 16'h5a3c;
    localparam logic [7:0]  VER = 8'h07;
    localparam logic [15:0] MID = 16'h2b61;
    logic        mclk = 1'b0, rst = 1'b1, ce = 1'b1, pin = 1'b0;
    logic        sclk, cs_n, sdi, sdo, oe, rd_stb, rcv, prc, mag, auto, evt;
    logic [7:0]  rd_byte, clk_b, byp, tsc;
    logic [3:0]  dly;
    logic [15:0] fs_a, fs_b;
    logic [23:0] phase = 24'h000000;
    logic [31:0] rnd = 32'h00011125;
    logic [7:0]  exp_q[$];
    logic [7:0]  v;
    logic [23:0] w;
    int          n_errors = 0, n_tests = 0, n_evt = 0;

    always #25 mclk = ~mclk;

    asr_regs #(.CHIP_IDENTITY_CODE(CID), .SILICON_VERSION(VER),
               .MAKER_IDENTITY(MID)) u_dut (
        .mclk(mclk), .rst(rst), .ce(ce), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe), .sysref_pin(pin),
        .edge_phase(phase), .sysref_receiver_enable(rcv),
        .sysref_processor_enable(prc), .sysref_position_magnify(mag),
        .sysref_delay_select(dly), .sysref_auto_cal(auto),
        .sysref_event(evt), .sync_clock_control_b(clk_b),
        .input_a_full_scale(fs_a), .input_b_full_scale(fs_b),
        .reference_bypass(byp), .timestamp_input_control(tsc));

    // Undriven data line reads inverted, so a missing enable shows up
    asr_host_model u_host (.mclk(mclk), .sdo(oe ? sdo : ~sdo), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .rd_stb(rd_stb), .rd_byte(rd_byte));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t read byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t port value %h expected %h", $time, got, exp);
        end
    endtask

    // Read bytes are matched against the oldest note
    always @(posedge mclk)
        if (rd_stb)
            chk_byte(rd_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);

    always @(posedge mclk)
        if (evt)
            n_evt++;

    task automatic rd(input logic [14:0] a, input int n, input logic [63:0] e);
        for (int k = 0; k < n; k++)
            exp_q.push_back(e[8 * (n - 1 - k) +: 8]);
        u_host.xfer(1'b1, a, n, 64'h0);
    endtask

    task automatic wr(input logic [14:0] a, input int n, input logic [63:0] d);
        u_host.xfer(1'b0, a, n, d);
    endtask

    // Hang guard: counts as a mismatch and closes the run
    initial begin
        repeat (100000) @(posedge mclk);
        n_errors++;
        complete_run;
    end

    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        chk_port({rcv, prc, mag, auto, dly}, 16'h0010);
        chk_port({clk_b, byp}, 16'h2000);
        rd(OFS_CONFIG, 1, 64'h30);
        rd(OFS_FAMILY_LO, 3, {CID[7:0], CID[15:8], VER});
        rd(OFS_MAKER_LO, 2, {MID[7:0], MID[15:8]});
        rd(OFS_CLK_A, 2, 64'h0020);
        rd(OFS_FS_A_LO, 4, 64'h00a000a0);
        $display("reset and identity test done");
        // Writes to read-only and unmapped places change nothing
        wr(OFS_FAMILY_LO, 3, 64'hffffff);
        wr(OFS_MAKER_LO, 2, 64'hffff);
        wr(15'h007, 1, 64'hff);
        wr(15'h02b, 1, 64'hff);
        rd(OFS_FAMILY_LO, 3, {CID[7:0], CID[15:8], VER});
        rd(OFS_MAKER_LO, 2, {MID[7:0], MID[15:8]});
        rd(15'h007, 1, 64'h0);
        rd(15'h02b, 1, 64'h0);
        $display("read-only test done");
        // Hold set: every byte lands on the same address
        wr(OFS_USER_CFG, 1, 64'hff);
        rd(OFS_USER_CFG, 1, 64'h01);
        rnd = xs(rnd);
        wr(OFS_BYPASS, 3, rnd[23:0]);
        rd(OFS_BYPASS, 3, {3{rnd[7:0]}});
        chk_port({8'h00, byp}, {8'h00, rnd[7:0]});
        wr(OFS_USER_CFG, 1, 64'h00);
        rd(15'h039, 1, 64'h0);
        $display("address hold test done");
        // Descending stream, then ascending readback
        wr(OFS_CONFIG, 1, 64'h00);
        rnd = xs(rnd);
        wr(OFS_FS_B_HI, 4, rnd);
        wr(OFS_CONFIG, 1, 64'h20);
        rd(OFS_FS_A_LO, 4, {rnd[7:0], rnd[15:8], rnd[23:16], rnd[31:24]});
        chk_port(fs_a, rnd[15:0]);
        chk_port(fs_b, rnd[31:16]);
        // Second clock and timestamp control registers take writes
        rnd = xs(rnd);
        wr(OFS_CLK_B, 1, rnd[7:0]);
        wr(OFS_SYNC_CTRL, 1, rnd[15:8]);
        chk_port({clk_b, tsc}, {rnd[7:0], rnd[15:8]});
        $display("address direction test done");
        // Control fields, delay code zero among them
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            v = {1'b0, rnd[6:4], 4'(i * 5)};
            v[5] = v[5] | v[6];
            wr(OFS_CLK_A, 1, v);
            rd(OFS_CLK_A, 1, v);
            chk_port({rcv, prc, mag, dly}, {v[5], v[6], v[4], v[3:0]});
            chk_port(auto, v[3:0] == 4'h0);
        end
        $display("control field test done");
        // Receiver only: sync edges are ignored
        wr(OFS_CLK_A, 1, 64'h20);
        rnd = xs(rnd);
        phase <= rnd[23:0];
        pin <= 1'b1;
        repeat (3) @(posedge mclk);
        pin <= 1'b0;
        repeat (8) @(posedge mclk);
        chk_port(16'(n_evt), 16'h0000);
        wr(OFS_CLK_A, 1, 64'h70);
        pin <= 1'b1;
        repeat (3) @(posedge mclk);
        pin <= 1'b0;
        repeat (8) @(posedge mclk);
        chk_port(16'(n_evt), 16'h0001);
        rd(OFS_POS_0, 3, {rnd[7:0], rnd[15:8], rnd[23:16]});
        // Unmagnified capture: each bit pair reads as its OR
        wr(OFS_CLK_A, 1, 64'h60);
        pin <= 1'b1;
        repeat (3) @(posedge mclk);
        pin <= 1'b0;
        repeat (8) @(posedge mclk);
        chk_port(16'(n_evt), 16'h0002);
        for (int i = 0; i < 24; i++)
            w[i] = rnd[i - i % 2] | rnd[i - i % 2 + 1];
        rd(OFS_POS_0, 3, {w[7:0], w[15:8], w[23:16]});
        wr(OFS_CLK_A, 1, {4'h7, rnd[3:0]});
        chk_port(dly, rnd[3:0]);
        $display("sync path test done");
        repeat (4) @(posedge mclk);
        chk_port(16'(exp_q.size()), 16'h0000);
        complete_run;
    end
endmodule
`default_nettype wire
